// File: src/amfp_pkg.sv
/*
 * Shared constants and types of the amplifier fault protection manager:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package amfp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned DC_DETECT_MS = 420;
    localparam int unsigned DC_DETECT_CYCLES = DC_DETECT_MS * (CLK_HZ / 1000);
    localparam int unsigned FAULT_RECOVERY_US = 1000;
    localparam int unsigned FAULT_RECOVERY_CYCLES = FAULT_RECOVERY_US * (CLK_HZ / 1000000);
    localparam int unsigned CNT_W = 24;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_EVENT = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;

    // Control fields
    localparam int unsigned CTRL_SD_BIT = 0;
    localparam int unsigned CTRL_PLS_BIT = 1;
    localparam int unsigned CTRL_FREQ_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    // Status fields beyond the six error bits
    localparam int unsigned NUM_ERR = 6;
    localparam int unsigned STAT_PLAY_BIT = 6;
    localparam int unsigned STAT_REC_BIT = 7;
    localparam logic [5:0] MASK_RESET = 6'h00;
    localparam logic [5:0] EVENT_RESET = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // Error vector, bit 0 first from the bottom
    typedef struct packed {
        logic die_heat_error;
        logic output_offset_error;
        logic current_limit_error;
        logic clocking_fault;
        logic supply_low_error;
        logic supply_high_error;
    } amfp_err_type;

    // Clock monitor flags
    typedef struct packed {
        logic ratio_bad;
        logic rate_bad;
        logic clk_stopped;
    } amfp_clk_type;

    // Effective static configuration; all zero is BTL at 16 x fs
    typedef struct packed {
        logic parallel_load_select;
        logic freq_8x;
    } amfp_cfg_type;

endpackage

// File: src/amfp_manager.sv
/*
 * Amplifier fault protection manager: classifies protection errors as
 * latching or non-latching, drives the open-drain fault indicator, runs
 * the recovery timer and the output offset qualifier, and selects the
 * hardware or software configuration. Registers sit on AHB-Lite.
 * Assumes all inputs synchronous to core_clk and an external pull-up
 * on the fault net.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Fault is signalled by pulling the open-drain low-active indicator low.
// - Latching error keeps indicator low until shutdown toggle and recovery time.
// - Non-latching errors except clock errors leave the indicator released.
// - Cleared non-latching errors resume playback without any shutdown toggle.
// - Clock error pulls indicator low; valid clocks resume playback at once.
// - Supply high is non-latching, silent, clears when supply falls back.
// - Supply low is non-latching, silent, clears when supply rises back.
// - Bad clock ratio, bad rate or stopped clock flags a clock error.
// - Overcurrent latches; clears after recovery time and shutdown toggle.
// - Output offset latches; clears after recovery time and shutdown toggle.
// - Overtemperature latches; also needs die below hysteresis to clear.
// - Same-polarity duty above 60% for over 420 ms trips offset error.
// - Hardware mode takes configuration only from static pins.
// - All static pins low selects BTL and 16 x fs switching.
// - Latching error still present at shutdown release is caught again.
// - Every error shows in a status bit; only latching and clock errors also pull the indicator.
module amfp_manager #(
    parameter int unsigned DC_CYCLES = amfp_pkg::DC_DETECT_CYCLES,
    parameter int unsigned RECOVERY_CYCLES = amfp_pkg::FAULT_RECOVERY_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic amp_shutdown_n,
    input wire logic hw_mode,
    input wire amfp_pkg::amfp_cfg_type cfg_pins,
    input wire logic supply_high,
    input wire logic supply_low,
    input wire amfp_pkg::amfp_clk_type clk_mon,
    input wire logic current_limit,
    input wire logic die_heat,
    input wire logic die_heat_hysteresis,
    input wire logic [1:0] duty_pos_high,
    input wire logic [1:0] duty_neg_high,
    output logic amp_fault_n_o,
    output logic amp_fault_n_oe,
    output logic play_en,
    output amfp_pkg::amfp_cfg_type cfg,
    output logic irq
);

    localparam int unsigned W = amfp_pkg::CNT_W;

    logic [2:0] ctrl;
    logic [5:0] mask;
    logic [5:0] events;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic sd_n;
    logic sd_q;
    logic sd_rise;
    logic clk_err;
    logic [1:0] dc_trip;
    logic [2:0] latched;
    logic [2:0] lat_cond;
    logic [W-1:0] rec_cnt;
    logic rec_busy;
    logic rec_done;
    amfp_pkg::amfp_err_type err_rep;
    amfp_pkg::amfp_err_type err_q;
    logic acc;
    logic rd_evt;

    // Single clock domain for every check in this module
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Shutdown request: pin, and the register bit in software mode
    assign sd_n = amp_shutdown_n & (hw_mode | ctrl[amfp_pkg::CTRL_SD_BIT]);
    assign sd_rise = sd_n & ~sd_q;

    // Previous shutdown level; resets high so leaving reset is no edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sd_q <= 1'b1;
        end else begin
            sd_q <= sd_n;
        end
    end

    // Any clock monitor flag is a clock error
    assign clk_err = |clk_mon;

    ////////////////////////////////////////////////////////////////////////
    // Output offset qualifier, one per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_dc
        logic [W-1:0] cnt;
        logic pol;
        logic act;
        assign act = duty_pos_high[ch] | duty_neg_high[ch];

        // Count while the duty stays high at one polarity
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                cnt <= '0;
                pol <= 1'b0;
            end else if (!act || pol != duty_pos_high[ch]) begin
                cnt <= '0;
                pol <= duty_pos_high[ch];
            end else if (cnt < W'(DC_CYCLES)) begin
                cnt <= cnt + W'(1);
            end
        end

        // Trips once the time is strictly exceeded
        assign dc_trip[ch] = act && pol == duty_pos_high[ch] && cnt >= W'(DC_CYCLES);

        a_dc_qualify: assert property (
            cnt == W'(DC_CYCLES - 1) && act && pol == duty_pos_high[ch]
            ##1 act && pol == duty_pos_high[ch] |-> dc_trip[ch]
        ) else $error("offset qualifier did not trip at the limit");
    end

    ////////////////////////////////////////////////////////////////////////
    // Recovery timer, started on the shutdown release
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rec_cnt <= '0;
            rec_busy <= 1'b0;
        end else if (!sd_n) begin
            rec_busy <= 1'b0;
            rec_cnt <= '0;
        end else if (sd_rise) begin
            rec_busy <= 1'b1;
            rec_cnt <= W'(RECOVERY_CYCLES);
        end else if (rec_busy) begin
            rec_cnt <= rec_cnt - W'(1);
            if (rec_cnt == W'(1)) begin
                rec_busy <= 1'b0;
            end
        end
    end

    assign rec_done = rec_busy && rec_cnt == W'(1);

    ////////////////////////////////////////////////////////////////////////
    // Latching errors: heat, offset, overcurrent
    assign lat_cond = {die_heat, |dc_trip, current_limit};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            latched <= 3'h0;
        end else begin
            // Set wins over clear; only seen while out of shutdown
            latched <= (rec_done ? {latched[2] & die_heat_hysteresis, 2'b00} : latched)
                       | (lat_cond & {3{sd_n}});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reported errors: live non-latching, held latching
    always_comb begin
        err_rep.supply_high_error = supply_high;
        err_rep.supply_low_error = supply_low;
        err_rep.clocking_fault = clk_err;
        err_rep.current_limit_error = latched[0];
        err_rep.output_offset_error = latched[1];
        err_rep.die_heat_error = latched[2];
    end

    // Indicator, playback and configuration from flip-flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            amp_fault_n_oe <= 1'b0;
            play_en <= 1'b0;
            err_q <= '0;
            cfg <= '0;
        end else begin
            amp_fault_n_oe <= (|latched) | clk_err;
            play_en <= sd_n && !rec_busy && latched == 3'h0
                       && !supply_high && !supply_low && !clk_err;
            err_q <= err_rep;
            if (hw_mode) begin
                cfg <= cfg_pins;
            end else begin
                cfg.parallel_load_select <= ctrl[amfp_pkg::CTRL_PLS_BIT];
                cfg.freq_8x <= ctrl[amfp_pkg::CTRL_FREQ_BIT];
            end
        end
    end

    // Open drain: only ever drives low
    assign amp_fault_n_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = hsel & hready & htrans[1];
    assign rd_evt = acc & ~hwrite & haddr[7:0] == amfp_pkg::OFF_EVENT;

    // Address phase capture and read data
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= acc & hwrite;
            wr_addr <= haddr[7:0];
            if (acc && !hwrite) begin
                unique case (haddr[7:0])
                    amfp_pkg::OFF_CTRL: hrdata <= {29'h0, ctrl};
                    amfp_pkg::OFF_STATUS: hrdata <= {24'h0, rec_busy, play_en, err_rep};
                    amfp_pkg::OFF_EVENT: hrdata <= {26'h0, events};
                    amfp_pkg::OFF_MASK: hrdata <= {26'h0, mask};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control and mask writes; control is frozen in hardware mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= amfp_pkg::CTRL_RESET;
            mask <= amfp_pkg::MASK_RESET;
        end else if (wr_pend) begin
            if (wr_addr == amfp_pkg::OFF_CTRL && !hw_mode) begin
                ctrl <= hwdata[2:0];
            end
            if (wr_addr == amfp_pkg::OFF_MASK) begin
                mask <= hwdata[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events on each error onset; read clears, set wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            events <= amfp_pkg::EVENT_RESET;
        end else begin
            events <= (rd_evt ? 6'h00 : events) | (err_rep & ~err_q);
        end
    end

    assign irq = |(events & mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_release;
        !sd_n ##1 sd_n;
    endsequence

    sequence s_recovered;
        rec_busy [*2] ##0 rec_cnt == W'(1);
    endsequence

    a_latch_pulls_low: assert property (
        |latched |=> amp_fault_n_oe
    ) else $error("latched error without indicator");

    a_supply_quiet: assert property (
        latched == 3'h0 && !clk_err |=> !amp_fault_n_oe
    ) else $error("indicator pulled without cause");

    a_clock_fault_pin: assert property (
        clk_err |=> amp_fault_n_oe && !play_en
    ) else $error("clock error not signalled");

    a_nonlatch_resume: assert property (
        $fell(supply_high | supply_low) && !clk_err && sd_n && !rec_busy
        && latched == 3'h0 |=> play_en
    ) else $error("no resume after non-latching error");

    a_latch_holds: assert property (
        latched[0] && !rec_done |=> latched[0]
    ) else $error("overcurrent cleared before recovery");

    a_heat_hyst: assert property (
        latched[2] && die_heat_hysteresis |=> latched[2]
    ) else $error("overtemperature cleared above hysteresis");

    a_redetect_release: assert property (
        s_release ##0 current_limit |=> latched[0] ##1 amp_fault_n_oe
    ) else $error("error not caught at shutdown release");

    a_recovery_wait: assert property (
        $fell(latched[1]) |-> $past(rec_done)
    ) else $error("offset cleared without timer expiry");

    a_timer_start: assert property (
        s_release |=> rec_busy && rec_cnt == W'(RECOVERY_CYCLES)
    ) else $error("recovery timer not started");

    a_expiry_clears: assert property (
        s_recovered ##0 !lat_cond[1] && sd_n |=> !latched[1]
    ) else $error("offset error kept after recovery");

    a_status_bits: assert property (
        |latched |=> err_q[5:3] == $past(latched)
    ) else $error("status does not follow latched errors");

    a_hw_config: assert property (
        hw_mode |=> cfg == $past(cfg_pins)
    ) else $error("hardware mode config not from pins");

    a_default_cfg: assert property (
        hw_mode && cfg_pins == '0 |=> cfg == '0
    ) else $error("default configuration not selected");

    a_clock_flag: assert property (
        clk_mon.clk_stopped |=> err_q.clocking_fault
    ) else $error("stopped clock not reported");

    a_fault_blocks_play: assert property (
        |latched |=> !play_en
    ) else $error("playback while a latched error is held");

    a_supply_silent: assert property (
        (supply_high || supply_low) && latched == 3'h0 && !clk_err
        |=> !amp_fault_n_oe && !play_en
    ) else $error("supply error pulled the indicator or kept playing");

    a_heat_release: assert property (
        rec_done && !die_heat_hysteresis && !die_heat |=> !latched[2]
    ) else $error("overtemperature kept after recovery below hysteresis");

endmodule

`default_nettype wire

// File: verification/amfp_host_model.sv
/*
 * Host side of the fault link: pulls the open-drain fault net up and
 * drives the shutdown pin, optionally looped back from the fault net.
 * Assumes the manager's open-drain split into level and enable.
 */
`timescale 1ns/1ps
`default_nettype none

module amfp_host_model (
    input wire logic fault_o,
    input wire logic fault_oe,
    input wire logic sd_req,
    input wire logic loop_en,
    output logic fault_net,
    output logic amp_shutdown_n
);
    ////////////////////////////////////////////////////////////////////////
    // External pull-up resolves the released net to high
    assign fault_net = fault_oe ? fault_o : 1'b1;
    // Shutdown pin is static or looped from the fault net
    assign amp_shutdown_n = loop_en ? fault_net : sd_req;
endmodule

`default_nettype wire

// File: verification/amp_fault_protection_manager_tb.sv
/*
 * Self-checking bench of the fault protection manager: register bus,
 * non-latching and latching faults, recovery, offset timer, hardware mode.
 * Assumes short recovery and offset counts set at the instance.
 */
`timescale 1ns/1ps
`default_nettype none

module amp_fault_protection_manager_tb;
    localparam int unsigned R = 8;
    localparam int unsigned DC = 20;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic hw_mode = 1'b0;
    amfp_pkg::amfp_cfg_type cfg_pins = '0;
    amfp_pkg::amfp_cfg_type cfg;
    logic supply_high = 1'b0;
    logic supply_low = 1'b0;
    amfp_pkg::amfp_clk_type clk_mon = '0;
    logic current_limit = 1'b0;
    logic die_heat = 1'b0;
    logic die_heat_hysteresis = 1'b0;
    logic [1:0] duty_pos_high = 2'h0;
    logic [1:0] duty_neg_high = 2'h0;
    logic fault_o, fault_oe, play_en, irq, fault_net, amp_shutdown_n;
    logic sd_req = 1'b1;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    integer seed = 31879;
    logic [31:0] r;
    logic [31:0] d;

    always #25 core_clk = ~core_clk;

    amfp_manager #(.DC_CYCLES(DC), .RECOVERY_CYCLES(R)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .amp_shutdown_n(amp_shutdown_n), .hw_mode(hw_mode), .cfg_pins(cfg_pins),
        .supply_high(supply_high), .supply_low(supply_low), .clk_mon(clk_mon),
        .current_limit(current_limit), .die_heat(die_heat),
        .die_heat_hysteresis(die_heat_hysteresis), .duty_pos_high(duty_pos_high),
        .duty_neg_high(duty_neg_high), .amp_fault_n_o(fault_o),
        .amp_fault_n_oe(fault_oe), .play_en(play_en), .cfg(cfg), .irq(irq));

    amfp_host_model i_host (.fault_o(fault_o), .fault_oe(fault_oe), .sd_req(sd_req),
        .loop_en(1'b0), .fault_net(fault_net), .amp_shutdown_n(amp_shutdown_n));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus helpers
    task automatic test_done;
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] mask_exp(input logic [31:0] v);
        return {26'h0, v[5:0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        r = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        ahb(1'b0, a, 32'h0);
        chk(name, r, exp);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // Waits a bounded time for the fault net and playback pair
    task automatic wait_for(input logic [1:0] want, input int n);
        int k;
        k = 0;
        while ({fault_net, play_en} !== want && k < n) begin
            tick(1);
            k++;
        end
        chk("fault_play", {30'h0, fault_net, play_en}, {30'h0, want});
    endtask

    // Toggles shutdown by pin or bit and checks the recovery wait
    task automatic recover(input logic by_bit, input logic ok);
        if (by_bit) begin
            ahb(1'b1, amfp_pkg::OFF_CTRL, 32'h0);
            ahb(1'b1, amfp_pkg::OFF_CTRL, 32'h1);
        end else begin
            sd_req <= 1'b0;
            tick(2);
            sd_req <= 1'b1;
        end
        tick(R - 2);
        chk("fault_early", {31'h0, fault_net}, 32'h0);
        if (ok) wait_for(2'b11, 8);
        else begin
            tick(8);
            chk("fault_held", {31'h0, fault_net}, 32'h0);
        end
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(10);
        arst_n <= 1'b1;
        wait_for(2'b11, R + 4);
        chk("cfg", {30'h0, cfg}, 32'h0);
        rd(amfp_pkg::OFF_STATUS, 32'h40, "status_idle");
        rd(amfp_pkg::OFF_CTRL, 32'h1, "ctrl");
        rd(amfp_pkg::OFF_MASK, 32'h0, "mask");
        rd(amfp_pkg::OFF_EVENT, 32'h0, "event");
        rd(8'h10, 32'h0, "unmapped");
        d = $random(seed);
        ahb(1'b1, amfp_pkg::OFF_MASK, d);
        rd(amfp_pkg::OFF_MASK, mask_exp(d), "mask_rb");
        ahb(1'b1, amfp_pkg::OFF_MASK, 32'h0);
        // Hardware mode ignores the control register
        hw_mode <= 1'b1;
        cfg_pins <= 2'($random(seed));
        ahb(1'b1, amfp_pkg::OFF_CTRL, 32'h6);
        tick(3);
        chk("cfg_hw", {30'h0, cfg}, {30'h0, cfg_pins});
        rd(amfp_pkg::OFF_CTRL, 32'h1, "ctrl_hw");
        chk("play_hw", {31'h0, play_en}, 32'h1);
        hw_mode <= 1'b0;
        cfg_pins <= '0;
        // Software mode takes the configuration from the control register
        ahb(1'b1, amfp_pkg::OFF_CTRL, 32'h7);
        tick(2);
        chk("cfg_sw", {30'h0, cfg}, 32'h3);
        ahb(1'b1, amfp_pkg::OFF_CTRL, 32'h1);
        // Supply errors are silent and self-clearing
        for (int i = 0; i < 2; i++) begin
            if (i == 0) supply_high <= 1'b1;
            else supply_low <= 1'b1;
            tick(3);
            chk("fault_supply", {30'h0, fault_net, play_en}, 32'h2);
            rd(amfp_pkg::OFF_STATUS, 32'h1 << i, "status_supply");
            supply_high <= 1'b0;
            supply_low <= 1'b0;
            wait_for(2'b11, 4);
        end
        // Each clock flag pulls the net and clears with no recovery delay
        for (int i = 0; i < 3; i++) begin
            clk_mon <= 3'h1 << i;
            tick(3);
            chk("fault_clk", {31'h0, fault_net}, 32'h0);
            rd(amfp_pkg::OFF_STATUS, 32'h4, "status_clk");
            clk_mon <= '0;
            wait_for(2'b11, 3);
        end
        // Overcurrent latches, raises an event and the masked interrupt
        current_limit <= 1'b1;
        tick(3);
        current_limit <= 1'b0;
        tick(20);
        chk("fault_oc", {30'h0, fault_net, play_en}, 32'h0);
        rd(amfp_pkg::OFF_STATUS, 32'h8, "status_oc");
        chk("irq_masked", {31'h0, irq}, 32'h0);
        ahb(1'b1, amfp_pkg::OFF_MASK, 32'h8);
        tick(1);
        chk("irq_on", {31'h0, irq}, 32'h1);
        rd(amfp_pkg::OFF_EVENT, 32'hF, "event_oc");
        tick(1);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        recover(1'b0, 1'b1);
        // Overcurrent still present at release is caught again
        current_limit <= 1'b1;
        tick(3);
        recover(1'b0, 1'b0);
        current_limit <= 1'b0;
        recover(1'b1, 1'b1);
        // Offset timer restarts on polarity change, then trips
        duty_pos_high <= 2'h1;
        tick(DC - 4);
        duty_pos_high <= 2'h0;
        duty_neg_high <= 2'h1;
        tick(DC - 4);
        chk("fault_offset_flip", {31'h0, fault_net}, 32'h1);
        tick(10);
        chk("fault_offset", {31'h0, fault_net}, 32'h0);
        rd(amfp_pkg::OFF_STATUS, 32'h10, "status_offset");
        duty_neg_high <= 2'h0;
        recover(1'b0, 1'b1);
        // Heat latch needs the die below hysteresis as well
        die_heat <= 1'b1;
        die_heat_hysteresis <= 1'b1;
        tick(3);
        die_heat <= 1'b0;
        rd(amfp_pkg::OFF_STATUS, 32'h20, "status_heat");
        recover(1'b0, 1'b0);
        die_heat_hysteresis <= 1'b0;
        recover(1'b1, 1'b1);
        test_done();
    end
endmodule

`default_nettype wire
